// ==== src/pcs_map.svh ====
// Register offsets, field positions and reset values of the clock control block
`ifndef PCS_MAP_SVH
`define PCS_MAP_SVH

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define PCS_OFF_PCK0 8'h00
`define PCS_OFF_PCK1 8'h04
`define PCS_OFF_IER 8'h08
`define PCS_OFF_IDR 8'h0C
`define PCS_OFF_SR 8'h10
`define PCS_OFF_IMR 8'h14
`define PCS_OFF_ICPR 8'h18
`define PCS_OFF_PLLA 8'h1C
`define PCS_OFF_EVT 8'h20

// ****************************************
// Programmable clock fields
// ****************************************
`define PCS_CSS_LSB 0
`define PCS_CSS_MSB 1
`define PCS_PRESCALE_SELECT_LSB 2
`define PCS_PRESCALE_SELECT_MSB 4
`define PCS_PCK_CFG_RST 5'h00
`define PCS_PRESCALE_SELECT_RESERVED 3'h7
`define PCS_CSS_SLOW 2'h0
`define PCS_CSS_MAIN 2'h1
`define PCS_CSS_PLLA 2'h2
`define PCS_CSS_PLLB 2'h3

// ****************************************
// Status, enable, disable, mask layout
// ****************************************
`define PCS_BIT_MAIN_OSC_STABLE 0
`define PCS_BIT_PLL_A_LOCKED 1
`define PCS_BIT_PLL_B_LOCKED 2
`define PCS_BIT_MASTER_CLOCK_READY 3
`define PCS_BIT_OSCSEL 7
`define PCS_BIT_PROG_CLOCK_READY_0 8
`define PCS_IRQ_BITS 32'h0000030F
`define PCS_MASK_RST 32'h0000030F

// ****************************************
// Charge pump and PLL A wait fields
// ****************************************
`define PCS_BIT_ICPA 0
`define PCS_BIT_ICPB 16
`define PCS_ICP_RST 1'b0
`define PCS_WAIT_LSB 8
`define PCS_WAIT_MSB 13
`define PCS_WAIT_RST 6'h00

`endif

// ==== src/pcs_pkg.sv ====
// Types shared by the clock control block
package pcs_pkg;
    typedef enum logic [1:0] {
        PCS_HALT,
        PCS_START,
        PCS_RUN
    } pcs_pck_state_e;

    typedef logic [4:0] pcs_pck_cfg_t;
endpackage

// ==== src/pcs_top.sv ====
// Programmable clocks, status, interrupt mask and charge pump registers
// Operation
// - Each programmable clock picks slow, main, PLL A or PLL B clock by a two-bit source select.
// - Each programmable clock divides its source by 1 to 64 in powers of two, code 111 reserved.
// - Writing the enable command register clears the disable state of every source written as one.
// - Writing the disable command register sets the disable state of every source written as one.
// - The mask register reads zero for an enabled and one for a disabled interrupt.
// - Enable, disable, mask and status share bits 0, 1, 2, 3, 8 and 9 for the six sources.
// - The main oscillator status bit reads one once the oscillator is stable.
// - The PLL A lock bit reads one while PLL A is locked.
// - The PLL B lock bit reads one while PLL B is locked.
// - The master clock ready bit reads one while the master clock is ready.
// - Status bit 7 reads zero for the internal RC and one for the external crystal slow oscillator.
// - Each programmable clock ready bit reads one while that output is ready.
// - After PLL A setup is written, its lock bit rises only after the programmed slow clock cycles.
//
// The plain strobed port and the placing of the registers were decided locally.
`timescale 1ns/1ps

`include "pcs_map.svh"

module pcs_top
    import pcs_pkg::*;
#(
    parameter int NUM_PCK = 2
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register port
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    // Clock sources, sampled on clk
    input wire logic slow_clk,
    input wire logic main_clk,
    input wire logic pll_a_clk,
    input wire logic pll_b_clk,
    // Oscillator and clock state
    input wire logic main_osc_stable,
    input wire logic pll_b_locked,
    input wire logic master_clock_ready,
    input wire logic slow_osc_choice,
    // Outputs
    output logic [NUM_PCK-1:0] prog_clk,
    output logic pll_a_pump_current,
    output logic pll_b_pump_current,
    output logic irq
);

    // ****************************************
    // Decode helpers
    // ****************************************
    function automatic logic pick_src(input logic [1:0] source_select, input logic [3:0] srcs);
        pick_src = srcs[source_select];
    endfunction

    function automatic logic [5:0] half_minus_one(input logic [2:0] prescale_select);
        half_minus_one = 6'((7'h01 << (prescale_select - 3'h1)) - 7'h01);
    endfunction

    // ****************************************
    // Address decode
    // ****************************************
    wire logic sel_ier = wr && (addr == `PCS_OFF_IER);
    wire logic sel_idr = wr && (addr == `PCS_OFF_IDR);
    wire logic sel_icpr = wr && (addr == `PCS_OFF_ICPR);
    wire logic sel_plla = wr && (addr == `PCS_OFF_PLLA);
    wire logic sel_evt = wr && (addr == `PCS_OFF_EVT);

    // ****************************************
    // Source sampling and slow clock edge
    // ****************************************
    logic [3:0] src_prev;
    wire logic [3:0] src_now = {pll_b_clk, pll_a_clk, main_clk, slow_clk};
    wire logic [3:0] src_rise = src_now & ~src_prev;

    always_ff @(posedge clk) begin
        if (rst) begin
            src_prev <= 4'h0;
        end else begin
            src_prev <= src_now;
        end
    end

    // ****************************************
    // Programmable clocks
    // ****************************************
    pcs_pck_cfg_t pck_cfg [NUM_PCK];
    pcs_pck_state_e pck_state [NUM_PCK];
    logic [5:0] pck_cnt [NUM_PCK];
    logic [NUM_PCK-1:0] pck_ready;

    genvar g;
    generate
        for (g = 0; g < NUM_PCK; g++) begin : g_pck
            wire logic sel_cfg = wr && (addr == 8'(`PCS_OFF_PCK0 + 4 * g));
            wire logic [1:0] source_select = pck_cfg[g][`PCS_CSS_MSB:`PCS_CSS_LSB];
            wire logic [2:0] prescale_select = pck_cfg[g][`PCS_PRESCALE_SELECT_MSB:`PCS_PRESCALE_SELECT_LSB];
            wire logic src_lvl = pick_src(source_select, src_now);
            wire logic src_edge = pick_src(source_select, src_rise);
            wire logic cnt_done = (pck_cnt[g] == half_minus_one(prescale_select));

            always_ff @(posedge clk) begin
                if (rst) begin
                    pck_cfg[g] <= `PCS_PCK_CFG_RST;
                end else if (sel_cfg) begin
                    pck_cfg[g] <= wdata[`PCS_PRESCALE_SELECT_MSB:`PCS_CSS_LSB];
                end
            end

            always_ff @(posedge clk) begin
                if (rst) begin
                    pck_state[g] <= PCS_START;
                    pck_cnt[g] <= 6'h00;
                    prog_clk[g] <= 1'b0;
                end else if (sel_cfg) begin
                    pck_state[g] <= (wdata[`PCS_PRESCALE_SELECT_MSB:`PCS_PRESCALE_SELECT_LSB] == `PCS_PRESCALE_SELECT_RESERVED) ?
                        PCS_HALT : PCS_START;
                    pck_cnt[g] <= 6'h00;
                    prog_clk[g] <= 1'b0;
                end else begin
                    case (pck_state[g])
                        PCS_HALT: begin
                            prog_clk[g] <= 1'b0;
                        end
                        PCS_START, PCS_RUN: begin
                            if (src_edge) begin
                                pck_state[g] <= PCS_RUN;
                            end
                            if (prescale_select == 3'h0) begin
                                prog_clk[g] <= src_lvl;
                            end else if (src_edge) begin
                                pck_cnt[g] <= cnt_done ? 6'h00 : pck_cnt[g] + 6'h01;
                                prog_clk[g] <= cnt_done ? ~prog_clk[g] : prog_clk[g];
                            end
                        end
                        default: begin
                            pck_state[g] <= PCS_HALT;
                        end
                    endcase
                end
            end

            assign pck_ready[g] = (pck_state[g] == PCS_RUN);
        end
    endgenerate

    // ****************************************
    // PLL A lock wait
    // ****************************************
    logic [5:0] pll_a_lock_wait;
    logic [5:0] pll_a_cnt;
    logic pll_a_locked;

    always_ff @(posedge clk) begin
        if (rst) begin
            pll_a_lock_wait <= `PCS_WAIT_RST;
            pll_a_cnt <= 6'h00;
            pll_a_locked <= 1'b0;
        end else if (sel_plla) begin
            pll_a_lock_wait <= wdata[`PCS_WAIT_MSB:`PCS_WAIT_LSB];
            pll_a_cnt <= 6'h00;
            pll_a_locked <= 1'b0;
        end else if (!pll_a_locked) begin
            if (pll_a_cnt == pll_a_lock_wait) begin
                pll_a_locked <= 1'b1;
            end else if (src_rise[`PCS_CSS_SLOW]) begin
                pll_a_cnt <= pll_a_cnt + 6'h01;
            end
        end
    end

    // ****************************************
    // Status vector
    // ****************************************
    logic [31:0] status;

    always_comb begin
        status = 32'h00000000;
        status[`PCS_BIT_MAIN_OSC_STABLE] = main_osc_stable;
        status[`PCS_BIT_PLL_A_LOCKED] = pll_a_locked;
        status[`PCS_BIT_PLL_B_LOCKED] = pll_b_locked;
        status[`PCS_BIT_MASTER_CLOCK_READY] = master_clock_ready;
        status[`PCS_BIT_OSCSEL] = slow_osc_choice;
        status[`PCS_BIT_PROG_CLOCK_READY_0 +: NUM_PCK] = pck_ready;
    end

    // ****************************************
    // Interrupt mask, events and output
    // ****************************************
    logic [31:0] irq_disabled;
    logic [31:0] irq_event;
    wire logic [31:0] irq_bits = `PCS_IRQ_BITS;
    wire logic [31:0] next_event = ((irq_event & ~(sel_evt ? wdata : 32'h00000000)) | status) & irq_bits;
    wire logic next_irq = |(next_event & ~irq_disabled);

    always_ff @(posedge clk) begin
        if (rst) begin
            irq_disabled <= `PCS_MASK_RST;
        end else if (sel_ier) begin
            irq_disabled <= irq_disabled & ~(wdata & irq_bits);
        end else if (sel_idr) begin
            irq_disabled <= irq_disabled | (wdata & irq_bits);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            irq_event <= 32'h00000000;
            irq <= 1'b0;
        end else begin
            irq_event <= next_event;
            irq <= next_irq;
        end
    end

    // ****************************************
    // Charge pump current
    // ****************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            pll_a_pump_current <= `PCS_ICP_RST;
            pll_b_pump_current <= `PCS_ICP_RST;
        end else if (sel_icpr) begin
            pll_a_pump_current <= wdata[`PCS_BIT_ICPA];
            pll_b_pump_current <= wdata[`PCS_BIT_ICPB];
        end
    end

    // ****************************************
    // Read data
    // ****************************************
    logic [31:0] rd_mux;

    always_comb begin
        rd_mux = 32'h00000000;
        case (addr)
            `PCS_OFF_PCK0: rd_mux = {27'h0, pck_cfg[0]};
            `PCS_OFF_PCK1: rd_mux = {27'h0, pck_cfg[NUM_PCK-1]};
            `PCS_OFF_SR: rd_mux = status;
            `PCS_OFF_IMR: rd_mux = irq_disabled;
            `PCS_OFF_PLLA: rd_mux = {18'h0, pll_a_lock_wait, 8'h00};
            `PCS_OFF_EVT: rd_mux = irq_event;
            default: rd_mux = 32'h00000000;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rdata <= 32'h00000000;
        end else begin
            rdata <= rd ? rd_mux : 32'h00000000;
        end
    end

endmodule // pcs_top

// ==== sim/pcs_top_properties.sv ====
// Port checks for the clock control block
`timescale 1ns/1ps

module pcs_top_properties
    import pcs_pkg::*;
#(
    parameter int NUM_PCK = 2
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register port
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [31:0] rdata,
    // Sources and states
    input wire logic slow_clk,
    input wire logic main_clk,
    input wire logic pll_a_clk,
    input wire logic pll_b_clk,
    input wire logic main_osc_stable,
    input wire logic pll_b_locked,
    input wire logic master_clock_ready,
    input wire logic slow_osc_choice,
    // Outputs
    input wire logic [NUM_PCK-1:0] prog_clk,
    input wire logic pll_a_pump_current,
    input wire logic pll_b_pump_current,
    input wire logic irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    chk_status_levels: assert property (
        rd && addr == 8'h10 && $stable({main_osc_stable, pll_b_locked, master_clock_ready, slow_osc_choice})
        |=> {rdata[0], rdata[2], rdata[3], rdata[7]} ==
            $past({main_osc_stable, pll_b_locked, master_clock_ready, slow_osc_choice}))
        else $error("status bits differ from inputs");
    chk_status_spare: assert property (rd && addr == 8'h10 |=> rdata[31:10] == 22'h0 && rdata[6:4] == 3'h0)
        else $error("status spare bits set");
    chk_mask_spare: assert property (rd && addr == 8'h14 |=> rdata[31:10] == 22'h0 && rdata[7:4] == 4'h0)
        else $error("mask spare bits set");
    chk_irq_enabled: assert property (wr && addr == 8'h08 && wdata[0] && main_osc_stable |-> ##[1:3] irq)
        else $error("irq missing after enable");
    chk_irq_disabled: assert property (wr && addr == 8'h0C && wdata[9:0] == 10'h30F |-> ##2 !irq)
        else $error("irq high with all disabled");
    chk_pump_copy: assert property (wr && addr == 8'h18
        |=> {pll_a_pump_current, pll_b_pump_current} == $past({wdata[0], wdata[16]}))
        else $error("pump bits not copied");
    chk_pump_hold: assert property (!(wr && addr == 8'h18) |=> $stable({pll_a_pump_current, pll_b_pump_current}))
        else $error("pump bits changed");
    chk_reserved_low: assert property (wr && addr == 8'h00 && wdata[4:2] == 3'h7 |=> !prog_clk[0] [*8])
        else $error("reserved prescale output not low");
endmodule // pcs_top_properties

// ==== sim/tb_top.sv ====
// Self-checking bench for the clock control block
`timescale 1ns/1ps

module tb_top;
    import pcs_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [31:0] rdata;
    logic [4:0] cnt = 5'h00;
    logic osc = 1'b0;
    logic pllb = 1'b0;
    logic mck = 1'b0;
    logic sel = 1'b0;
    logic [1:0] pck;
    logic pa, pb, irq;
    logic [31:0] d;
    int fails = 0;
    int num_checks = 0;
    int n;
    int per[4] = '{16, 4, 8, 32};

    always #2.5 clk = ~clk;
    always @(posedge clk) cnt <= cnt + 5'h01;

    pcs_top #(.NUM_PCK(2)) pcs_top_inst (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .slow_clk(cnt[3]), .main_clk(cnt[1]), .pll_a_clk(cnt[2]), .pll_b_clk(cnt[4]),
        .main_osc_stable(osc), .pll_b_locked(pllb), .master_clock_ready(mck), .slow_osc_choice(sel),
        .prog_clk(pck), .pll_a_pump_current(pa), .pll_b_pump_current(pb), .irq(irq));

    // ****************************************
    // Bus and compare tasks
    // ****************************************
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask

    task automatic wait_cyc(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", name, exp, got);
            fails++;
        end
    endtask

    task automatic rise(input int i, inout int k);
        while (pck[i] !== 1'b0 && k < 5000) begin @(posedge clk); k++; end
        while (pck[i] !== 1'b1 && k < 5000) begin @(posedge clk); k++; end
    endtask

    task automatic measure(input int i, output int k);
        k = 0;
        rise(i, k);
        k = 0;
        rise(i, k);
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // ****************************************
    // Tests
    // ****************************************
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        rd_reg(8'h14, d); chk("mask_reset", 32'h30F, d);
        rd_reg(8'h24, d); chk("unmapped", 32'h0, d);
        wr_reg(8'h08, 32'hFFFFFC01); rd_reg(8'h14, d); chk("mask_en0", 32'h30E, d);
        wr_reg(8'h08, 32'h200); rd_reg(8'h14, d); chk("mask_en9", 32'h10E, d);
        wr_reg(8'h0C, 32'h201); wr_reg(8'h14, 32'h0); rd_reg(8'h14, d); chk("mask_dis", 32'h30F, d);
        $display("test mask done");
        osc <= 1'b1; wait_cyc(4); chk("irq_masked", 32'h0, irq);
        wr_reg(8'h08, 32'h1); wait_cyc(3); chk("irq_on", 32'h1, irq);
        osc <= 1'b0; wait_cyc(4); chk("irq_sticky", 32'h1, irq);
        wr_reg(8'h20, 32'h1); wait_cyc(3); chk("irq_clear", 32'h0, irq);
        wr_reg(8'h0C, 32'h30F);
        $display("test irq done");
        {osc, pllb, mck, sel} <= 4'hF; wait_cyc(4);
        rd_reg(8'h10, d); chk("status_high", 32'h38F, d);
        {osc, pllb, mck, sel} <= 4'h0; wait_cyc(4);
        rd_reg(8'h10, d); chk("status_low", 32'h302, d);
        wr_reg(8'h1C, 32'h300); rd_reg(8'h10, d); chk("lock_wait", 32'h300, d);
        wait_cyc(80); rd_reg(8'h10, d); chk("lock_set", 32'h302, d);
        wr_reg(8'h18, 32'h00010001); wait_cyc(1); chk("pump", 32'h3, {pa, pb});
        $display("test status done");
        for (int s = 0; s < 4; s++) begin
            wr_reg(8'h00, 32'h4 | s); measure(0, n); chk("source", 2 * per[s], n);
        end
        for (int p = 0; p < 7; p++) begin
            wr_reg(8'h04, (p << 2) | 1); measure(1, n); chk("prescale", 4 << p, n);
        end
        rd_reg(8'h04, d); chk("cfg_read", 32'h19, d);
        wr_reg(8'h00, 32'h1C); rd_reg(8'h10, d); chk("ready_drop", 32'h202, d);
        wait_cyc(40); rd_reg(8'h10, d); chk("reserved", 32'h202, d);
        chk("reserved_out", 32'h0, pck[0]);
        wr_reg(8'h00, 32'h1); wait_cyc(20); rd_reg(8'h10, d); chk("ready_back", 32'h302, d);
        wait_cyc(1); chk("rdata_idle", 32'h0, rdata);
        $display("test clocks done");
        summarize();
    end

    initial begin
        #100000;
        fails++;
        summarize();
    end
endmodule // tb_top

bind pcs_top pcs_top_properties #(.NUM_PCK(NUM_PCK)) pcs_top_properties_inst (.clk(clk), .rst(rst),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .slow_clk(slow_clk), .main_clk(main_clk),
    .pll_a_clk(pll_a_clk), .pll_b_clk(pll_b_clk), .main_osc_stable(main_osc_stable),
    .pll_b_locked(pll_b_locked), .master_clock_ready(master_clock_ready), .slow_osc_choice(slow_osc_choice),
    .prog_clk(prog_clk), .pll_a_pump_current(pll_a_pump_current), .pll_b_pump_current(pll_b_pump_current),
    .irq(irq));
